// file: hw/usx_pkg.sv
/*
  usx_pkg: register map, bit positions and types for the synchronous
  serial channel. Assumes an APB master with 32-bit data and byte addresses.
*/
`default_nettype none
// What this block does
// - receive starts when continuous enable set, or single enable in master mode
// - data sampled on shift clock falling edge
// - single gives one word; continuous wins
// - last bit moves word to fifo, flag set
// - receive flag read-only, clears when fifo empty
// - interrupt only when receive enable bit set
// - receive fifo holds two words
// - third word into full fifo sets overrun
// - overrun cleared only by clearing continuous enable
// - overrun blocks all moves into fifo
// - ninth bit and framing error travel per word
// - ninth-bit select receives nine bits per word
// - dropping enables resets receive logic
// - slave mode: partner drives clock, we never
// - slave mode keeps shifting during core sleep
// - transmit flag set when buffered word moves
// - enabled transmit flag wakes the core
// - dropping port or transmit enable resets transmitter
package usx_pkg;
  // register indices; byte address is four times the index
  localparam logic [7:0] IDX_FLAGS = 8'h10;
  localparam logic [7:0] IDX_ENABLES = 8'h11;
  localparam logic [7:0] IDX_RECEIVE_STATUS_CONTROL = 8'h13;
  localparam logic [7:0] IDX_RECEIVE_DATA_BUFFER = 8'h14;
  localparam logic [7:0] IDX_TRANSMIT_STATUS_CONTROL = 8'h15;
  localparam logic [7:0] IDX_TRANSMIT_DATA_BUFFER = 8'h16;
  localparam logic [7:0] IDX_BAUD = 8'h17;
  localparam int unsigned B_SERIAL_PORT_ENABLE = 7;
  localparam int unsigned B_RX9 = 6;
  localparam int unsigned B_SINGLE_RECEIVE_ENABLE = 5;
  localparam int unsigned B_CONTINUOUS_RECEIVE_ENABLE = 4;
  localparam int unsigned B_CLOCK_SOURCE_SELECT = 7;
  localparam int unsigned B_TX9 = 6;
  localparam int unsigned B_TRANSMIT_ENABLE = 5;
  localparam int unsigned B_SYNC = 4;
  localparam int unsigned B_TRANSMIT_NINTH_BIT = 0;
  localparam int unsigned B_RECEIVE_INTERRUPT_FLAG = 0;
  localparam int unsigned B_TRANSMIT_INTERRUPT_FLAG = 1;
  localparam logic [3:0] BITS8 = 4'h8;
  localparam logic [3:0] BITS9 = 4'h9;
  localparam logic [1:0] FIFO_FULL = 2'h2;
  typedef struct packed {
    logic framing_error;
    logic ninth;
    logic [7:0] data;
  } usx_rx_word_s;
  function automatic logic [7:0] usx_addr(input logic [7:0] idx);
    return {idx[5:0], 2'b00};
  endfunction : usx_addr
endpackage : usx_pkg
`default_nettype wire

// file: hw/usx_top.sv
/*
  usx_top: one synchronous serial channel with APB registers, two-deep
  receive fifo, master clock generator and slave clock edge detection.
  Assumes pin inputs are asynchronous and a core that reports sleep.
*/
// Chosen here: the APB interface to the registers.
`default_nettype none
module usx_top
  import usx_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic clk_en,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic serial_clock_pin_in,
  output logic serial_clock_pin_out,
  output logic serial_clock_pin_oe,
  input wire logic serial_data_pin_in,
  output logic serial_data_pin_out,
  output logic serial_data_pin_oe,
  input wire logic core_sleep,
  output logic rx_irq,
  output logic tx_irq,
  output logic wake_req
);
  logic serial_port_enable_q, rx9_q, single_receive_enable_q, continuous_receive_enable_q;
  logic clock_source_select_q, tx9_q, transmit_enable_q, sync_q, transmit_ninth_bit_q;
  logic receive_interrupt_enable_q, transmit_interrupt_enable_q;
  logic [7:0] baud_q;
  logic [31:0] prdata_q;
  logic ck_s1_q, ck_s2_q, ck_s3_q, dt_s1_q, dt_s2_q;
  logic [7:0] brg_q;
  logic mck_q;
  logic [8:0] rsr_q;
  logic [3:0] rbit_q;
  usx_rx_word_s fifo_q [2];
  logic wptr_q, rptr_q;
  logic [1:0] cnt_q;
  logic overrun_error_q;
  logic [7:0] txbuf_q;
  logic txfull_q;
  logic [8:0] tsr_q;
  logic [3:0] tbit_q;
  logic tbusy_q, dt_o_q;

  logic wr, rd, setup;
  logic wr_receive_status_control, wr_transmit_status_control, wr_transmit_data_buffer, rd_receive_data_buffer;
  logic mapped;
  logic run, tick, rise, fall;
  logic rx_on, tx_on, rx_done, push, pop, single_receive_enable_done, ovr_set, load;
  logic [3:0] rx_nb, tx_nb;
  logic [8:0] rsr_nxt;
  usx_rx_word_s rx_word, head;
  logic receive_interrupt_flag, transmit_interrupt_flag;

  function automatic logic hit(input logic [7:0] a, input logic [7:0] idx);
    return a == usx_addr(idx);
  endfunction : hit

  assign setup = psel && !penable;
  assign wr = psel && penable && pwrite && clk_en;
  assign rd = psel && penable && !pwrite && clk_en;
  assign wr_receive_status_control = wr && hit(paddr, IDX_RECEIVE_STATUS_CONTROL);
  assign wr_transmit_status_control = wr && hit(paddr, IDX_TRANSMIT_STATUS_CONTROL);
  assign wr_transmit_data_buffer = wr && hit(paddr, IDX_TRANSMIT_DATA_BUFFER);
  assign rd_receive_data_buffer = rd && hit(paddr, IDX_RECEIVE_DATA_BUFFER);
  assign mapped = hit(paddr, IDX_FLAGS) || hit(paddr, IDX_ENABLES)
    || hit(paddr, IDX_RECEIVE_STATUS_CONTROL) || hit(paddr, IDX_RECEIVE_DATA_BUFFER)
    || hit(paddr, IDX_TRANSMIT_STATUS_CONTROL) || hit(paddr, IDX_TRANSMIT_DATA_BUFFER)
    || hit(paddr, IDX_BAUD);
  assign pready = 1'b1;
  assign pslverr = psel && penable && !mapped;
  assign prdata = prdata_q;

  assign head = fifo_q[rptr_q];
  assign receive_interrupt_flag = cnt_q != 2'h0;
  assign transmit_interrupt_flag = !txfull_q;
  assign rx_irq = receive_interrupt_flag && receive_interrupt_enable_q;
  assign tx_irq = transmit_interrupt_flag && transmit_interrupt_enable_q;
  assign wake_req = core_sleep && (rx_irq || tx_irq);

  // slave mode ignores the single enable
  assign rx_on = serial_port_enable_q && sync_q && (continuous_receive_enable_q || (single_receive_enable_q && clock_source_select_q));
  assign tx_on = serial_port_enable_q && sync_q && transmit_enable_q && !rx_on;
  // master clock stops in sleep; a slave keeps shifting on partner edges
  assign run = serial_port_enable_q && sync_q && clock_source_select_q && !core_sleep
    && (rx_on || (tx_on && tbusy_q));
  assign tick = run && (brg_q == baud_q);
  assign rise = clock_source_select_q ? (tick && !mck_q) : (ck_s2_q && !ck_s3_q);
  assign fall = clock_source_select_q ? (tick && mck_q) : (!ck_s2_q && ck_s3_q);

  assign rx_nb = rx9_q ? BITS9 : BITS8;
  assign tx_nb = tx9_q ? BITS9 : BITS8;
  assign rsr_nxt = {dt_s2_q, rsr_q[8:1]};
  assign rx_done = fall && rx_on && (rbit_q == rx_nb - 4'h1);
  always_comb
  begin
    rx_word.framing_error = 1'b0;
    rx_word.ninth = rx9_q ? rsr_nxt[8] : 1'b0;
    rx_word.data = rx9_q ? rsr_nxt[7:0] : rsr_nxt[8:1];
  end
  assign push = rx_done && !overrun_error_q && (cnt_q != FIFO_FULL);
  assign ovr_set = rx_done && !overrun_error_q && (cnt_q == FIFO_FULL);
  assign pop = rd_receive_data_buffer && receive_interrupt_flag;
  assign single_receive_enable_done = rx_done && !continuous_receive_enable_q && clock_source_select_q;
  assign load = tx_on && !tbusy_q && txfull_q;

  assign serial_clock_pin_out = mck_q;
  assign serial_clock_pin_oe = serial_port_enable_q && sync_q && clock_source_select_q;
  assign serial_data_pin_out = dt_o_q;
  assign serial_data_pin_oe = tx_on && tbusy_q;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      serial_port_enable_q <= 1'b0;
      rx9_q <= 1'b0;
      single_receive_enable_q <= 1'b0;
      continuous_receive_enable_q <= 1'b0;
    end
    else if (clk_en)
    begin
      if (wr_receive_status_control)
      begin
        serial_port_enable_q <= pwdata[B_SERIAL_PORT_ENABLE];
        rx9_q <= pwdata[B_RX9];
        single_receive_enable_q <= pwdata[B_SINGLE_RECEIVE_ENABLE];
        continuous_receive_enable_q <= pwdata[B_CONTINUOUS_RECEIVE_ENABLE];
      end
      else if (single_receive_enable_done)
        single_receive_enable_q <= 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      clock_source_select_q <= 1'b0;
      tx9_q <= 1'b0;
      transmit_enable_q <= 1'b0;
      sync_q <= 1'b0;
      transmit_ninth_bit_q <= 1'b0;
      receive_interrupt_enable_q <= 1'b0;
      transmit_interrupt_enable_q <= 1'b0;
      baud_q <= 8'h00;
    end
    else if (clk_en && wr)
    begin
      if (hit(paddr, IDX_TRANSMIT_STATUS_CONTROL))
      begin
        clock_source_select_q <= pwdata[B_CLOCK_SOURCE_SELECT];
        tx9_q <= pwdata[B_TX9];
        transmit_enable_q <= pwdata[B_TRANSMIT_ENABLE];
        sync_q <= pwdata[B_SYNC];
        transmit_ninth_bit_q <= pwdata[B_TRANSMIT_NINTH_BIT];
      end
      if (hit(paddr, IDX_ENABLES))
      begin
        receive_interrupt_enable_q <= pwdata[B_RECEIVE_INTERRUPT_FLAG];
        transmit_interrupt_enable_q <= pwdata[B_TRANSMIT_INTERRUPT_FLAG];
      end
      if (hit(paddr, IDX_BAUD))
        baud_q <= pwdata[7:0];
    end
  end

  // read data is captured in the setup phase so pready can stay high
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      prdata_q <= 32'h0000_0000;
    else if (clk_en && setup)
    begin
      prdata_q <= 32'h0000_0000;
      if (hit(paddr, IDX_FLAGS))
        prdata_q[B_TRANSMIT_INTERRUPT_FLAG:B_RECEIVE_INTERRUPT_FLAG] <= {transmit_interrupt_flag, receive_interrupt_flag};
      if (hit(paddr, IDX_ENABLES))
        prdata_q[B_TRANSMIT_INTERRUPT_FLAG:B_RECEIVE_INTERRUPT_FLAG] <= {transmit_interrupt_enable_q, receive_interrupt_enable_q};
      // an empty fifo has no current word, so its status bits read 0
      if (hit(paddr, IDX_RECEIVE_STATUS_CONTROL))
        prdata_q[7:0] <= {serial_port_enable_q, rx9_q, single_receive_enable_q, continuous_receive_enable_q, 1'b0,
          head.framing_error && receive_interrupt_flag, overrun_error_q, head.ninth && receive_interrupt_flag};
      if (hit(paddr, IDX_RECEIVE_DATA_BUFFER))
        prdata_q[7:0] <= head.data;
      if (hit(paddr, IDX_TRANSMIT_STATUS_CONTROL))
        prdata_q[7:0] <= {clock_source_select_q, tx9_q, transmit_enable_q, sync_q, 2'b00,
          !tbusy_q, transmit_ninth_bit_q};
      if (hit(paddr, IDX_TRANSMIT_DATA_BUFFER))
        prdata_q[7:0] <= txbuf_q;
      if (hit(paddr, IDX_BAUD))
        prdata_q[7:0] <= baud_q;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ck_s1_q <= 1'b0;
      ck_s2_q <= 1'b0;
      ck_s3_q <= 1'b0;
      dt_s1_q <= 1'b0;
      dt_s2_q <= 1'b0;
    end
    else if (clk_en)
    begin
      ck_s1_q <= serial_clock_pin_in;
      ck_s2_q <= ck_s1_q;
      ck_s3_q <= ck_s2_q;
      dt_s1_q <= serial_data_pin_in;
      dt_s2_q <= dt_s1_q;
    end
  end

  // half period of the master clock is baud divisor plus one cycles
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      brg_q <= 8'h00;
      mck_q <= 1'b0;
    end
    else if (clk_en)
    begin
      if (!run)
      begin
        brg_q <= 8'h00;
        mck_q <= 1'b0;
      end
      else if (tick)
      begin
        brg_q <= 8'h00;
        mck_q <= !mck_q;
      end
      else
        brg_q <= brg_q + 8'h01;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      rsr_q <= 9'h000;
      rbit_q <= 4'h0;
    end
    else if (clk_en)
    begin
      if (!rx_on)
      begin
        rsr_q <= 9'h000;
        rbit_q <= 4'h0;
      end
      else if (fall)
      begin
        rsr_q <= rsr_nxt;
        rbit_q <= rx_done ? 4'h0 : rbit_q + 4'h1;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      fifo_q[0] <= '0;
      fifo_q[1] <= '0;
      wptr_q <= 1'b0;
      rptr_q <= 1'b0;
      cnt_q <= 2'h0;
    end
    else if (clk_en)
    begin
      if (push)
      begin
        fifo_q[wptr_q] <= rx_word;
        wptr_q <= !wptr_q;
      end
      if (pop)
        rptr_q <= !rptr_q;
      cnt_q <= cnt_q + {1'b0, push} - {1'b0, pop};
    end
  end

  // a new overrun beats a clearing write in the same cycle
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      overrun_error_q <= 1'b0;
    else if (clk_en)
    begin
      if (ovr_set)
        overrun_error_q <= 1'b1;
      else if (wr_receive_status_control && !pwdata[B_CONTINUOUS_RECEIVE_ENABLE])
        overrun_error_q <= 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      txbuf_q <= 8'h00;
      txfull_q <= 1'b0;
    end
    else if (clk_en)
    begin
      if (wr_transmit_data_buffer)
      begin
        txbuf_q <= pwdata[7:0];
        txfull_q <= 1'b1;
      end
      else if (load)
        txfull_q <= 1'b0;
    end
  end

  // a receive that interrupts a send freezes it without a reset
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      tsr_q <= 9'h000;
      tbit_q <= 4'h0;
      tbusy_q <= 1'b0;
      dt_o_q <= 1'b0;
    end
    else if (clk_en)
    begin
      if (!(serial_port_enable_q && transmit_enable_q))
      begin
        tbusy_q <= 1'b0;
        tbit_q <= 4'h0;
        dt_o_q <= 1'b0;
      end
      else if (load)
      begin
        tsr_q <= {transmit_ninth_bit_q, txbuf_q};
        tbit_q <= 4'h0;
        tbusy_q <= 1'b1;
      end
      else if (tx_on && tbusy_q && rise && tbit_q != tx_nb)
      begin
        dt_o_q <= tsr_q[0];
        tsr_q <= {1'b0, tsr_q[8:1]};
        tbit_q <= tbit_q + 4'h1;
      end
      else if (tx_on && tbusy_q && fall && tbit_q == tx_nb)
        tbusy_q <= 1'b0;
    end
  end

  chk_push_flag: assert property (@(posedge pclk) disable iff (!presetn)
    push && clk_en |=> receive_interrupt_flag)
    else $error("received word did not raise the receive flag");
  chk_flag_clear: assert property (@(posedge pclk) disable iff (!presetn)
    $fell(receive_interrupt_flag) |-> $past(pop) && $past(cnt_q) == 2'h1)
    else $error("receive flag cleared while data remained");
  chk_irq_gate: assert property (@(posedge pclk) disable iff (!presetn)
    rx_irq |-> receive_interrupt_enable_q && cnt_q != 2'h0)
    else $error("receive interrupt without enable or data");
  chk_fifo_depth: assert property (@(posedge pclk) disable iff (!presetn)
    cnt_q <= FIFO_FULL)
    else $error("receive fifo above two words");
  chk_overrun_set: assert property (@(posedge pclk) disable iff (!presetn)
    clk_en && rx_done && cnt_q == FIFO_FULL |=> overrun_error_q && cnt_q != 2'h0)
    else $error("third word into full fifo missed overrun");
  chk_overrun_hold: assert property (@(posedge pclk) disable iff (!presetn)
    $fell(overrun_error_q) |-> $past(wr_receive_status_control) && !$past(pwdata[B_CONTINUOUS_RECEIVE_ENABLE]))
    else $error("overrun cleared without clearing continuous enable");
  chk_overrun_block: assert property (@(posedge pclk) disable iff (!presetn)
    overrun_error_q && clk_en |=> $stable(wptr_q))
    else $error("fifo written while overrun set");
  chk_single_once: assert property (@(posedge pclk) disable iff (!presetn)
    clk_en && single_receive_enable_done && !wr_receive_status_control |=> !single_receive_enable_q && !rx_on)
    else $error("single receive did not stop after one word");
  chk_slave_clock: assert property (@(posedge pclk) disable iff (!presetn)
    !clock_source_select_q |-> !serial_clock_pin_oe && !run)
    else $error("clock pin driven in slave mode");
  chk_tx_abort: assert property (@(posedge pclk) disable iff (!presetn)
    clk_en && !transmit_enable_q |=> !tbusy_q && !serial_data_pin_oe)
    else $error("transmitter still busy after enable dropped");
  chk_transmit_interrupt_flag_move: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(transmit_interrupt_flag) |-> $past(load))
    else $error("transmit flag rose without a move to the shifter");

  cov_fifo_full: cover property (@(posedge pclk) push ##[1:400] push);
  cov_overrun: cover property (@(posedge pclk) ovr_set);
  cov_tx_two: cover property (@(posedge pclk) load ##[1:400] load);
  cov_sleep_wake: cover property (@(posedge pclk) wake_req && !clock_source_select_q);
endmodule : usx_top
`default_nettype wire

// file: bench/usx_peer.sv
/*
  usx_peer: far-side synchronous serial device. It feeds bits to the
  channel's master clock and runs its own clock in slave mode.
  Assumes the bench resolves both lines from all parties' enables.
*/
`default_nettype none
module usx_peer
(
  input wire logic ck,
  input wire logic dt,
  output logic ck_drv,
  output logic ck_drv_oe,
  output logic dt_drv,
  output logic [7:0] cap
);
  timeunit 1ns;
  timeprecision 100ps;
  logic bits_q[$];
  initial
  begin
    ck_drv = 1'b0;
    ck_drv_oe = 1'b0;
    dt_drv = 1'b0;
    cap = 8'h00;
  end
  // an empty queue toggles the line so a stale bit never looks valid
  always @(posedge ck)
    dt_drv <= (bits_q.size() > 0) ? bits_q.pop_front() : ~dt_drv;
  task automatic queue_word(input logic [8:0] w, input int n);
    for (int i = 0; i < n; i++)
      bits_q.push_back(w[i]);
  endtask : queue_word
  // clock stands low between frames; data taken at each falling edge
  task automatic pulses(input int n);
    ck_drv_oe = 1'b1;
    for (int i = 0; i < n; i++)
    begin
      #62.5 ck_drv = 1'b1;
      #62.5 ck_drv = 1'b0;
      cap = {dt, cap[7:1]};
    end
    ck_drv_oe = 1'b0;
  endtask : pulses
endmodule : usx_peer
`default_nettype wire

// file: bench/tb_usart_sync_rx_and_slave_tx.sv
/*
  tb_usart_sync_rx_and_slave_tx: self-checking bench for usx_top.
  Assumes usx_peer on the serial lines and an APB master in the bench.
*/
`default_nettype none
module tb_usart_sync_rx_and_slave_tx
  import usx_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  `define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin miscompares++; \
    $display("wrong value at %0t: %h vs %h", $time, g, e); end end
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, core_sleep, err;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic ck_o, ck_oe, dt_o, dt_oe, rx_irq, tx_irq, wake_req, p_ck, p_ck_oe, p_dt;
  logic [7:0] cap;
  int miscompares = 0;
  int n_tests = 0;
  // nobody driving the clock leaves it at its pull-down idle level
  wire logic ck = ck_oe ? ck_o : (p_ck_oe ? p_ck : 1'b0);
  wire logic dt = dt_oe ? dt_o : p_dt;
  usx_top dut (.pclk(pclk), .presetn(presetn), .clk_en(1'b1), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .serial_clock_pin_in(ck),
    .serial_clock_pin_out(ck_o), .serial_clock_pin_oe(ck_oe), .serial_data_pin_in(dt),
    .serial_data_pin_out(dt_o), .serial_data_pin_oe(dt_oe), .core_sleep(core_sleep),
    .rx_irq(rx_irq), .tx_irq(tx_irq), .wake_req(wake_req));
  usx_peer peer (.ck(ck), .dt(dt), .ck_drv(p_ck), .ck_drv_oe(p_ck_oe), .dt_drv(p_dt),
    .cap(cap));
  initial
  begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end
  task tally_and_finish;
    if (miscompares == 0 && n_tests > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : tally_and_finish
  // entered just after a rising edge, returns just after one
  task apb(input logic w, input logic [7:0] idx, input logic [31:0] wd);
    int n;
    n = 0;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= {idx[5:0], 2'b00};
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    do
    begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
    if (n >= 20)
    begin
      miscompares++;
      tally_and_finish();
    end
  endtask : apb
  task wr(input logic [7:0] idx, input logic [31:0] d);
    apb(1'b1, idx, d);
  endtask : wr
  task rdchk(input logic [7:0] idx, input logic [31:0] m, input logic [31:0] e);
    apb(1'b0, idx, 32'h0);
    `CHK(rd & m, e)
  endtask : rdchk
  task waitbit(input logic [7:0] idx, input logic [31:0] m);
    int n;
    n = 0;
    do
    begin
      apb(1'b0, idx, 32'h0);
      n++;
    end while ((rd & m) == 32'h0 && n < 300);
    if (n >= 300)
    begin
      miscompares++;
      tally_and_finish();
    end
  endtask : waitbit
  task t_reset;
    rdchk(IDX_FLAGS, 32'hffffffff, 32'h2);
    rdchk(IDX_ENABLES, 32'hffffffff, 32'h0);
    wr(IDX_FLAGS, 32'h0);
    rdchk(IDX_FLAGS, 32'hff, 32'h2);
    apb(1'b0, 8'h30, 32'h0);
    `CHK({err, rd}, {1'b1, 32'h0})
  endtask : t_reset
  task t_single;
    wr(IDX_BAUD, 32'h2);
    wr(IDX_TRANSMIT_STATUS_CONTROL, 32'h90);
    peer.queue_word(9'h0a5, 8);
    wr(IDX_RECEIVE_STATUS_CONTROL, 32'ha0);
    waitbit(IDX_FLAGS, 32'h1);
    `CHK(rx_irq, 1'b0)
    wr(IDX_ENABLES, 32'h1);
    `CHK(rx_irq, 1'b1)
    rdchk(IDX_RECEIVE_STATUS_CONTROL, 32'hff, 32'h80);
    rdchk(IDX_RECEIVE_DATA_BUFFER, 32'hff, 32'ha5);
    rdchk(IDX_FLAGS, 32'h1, 32'h0);
    wr(IDX_ENABLES, 32'h0);
  endtask : t_single
  task t_overrun;
    peer.queue_word(9'h113, 9);
    peer.queue_word(9'h02c, 9);
    peer.queue_word(9'h177, 9);
    wr(IDX_RECEIVE_STATUS_CONTROL, 32'hf0);
    waitbit(IDX_RECEIVE_STATUS_CONTROL, 32'h2);
    rdchk(IDX_RECEIVE_STATUS_CONTROL, 32'h7, 32'h3);
    rdchk(IDX_RECEIVE_DATA_BUFFER, 32'hff, 32'h13);
    rdchk(IDX_RECEIVE_STATUS_CONTROL, 32'h7, 32'h2);
    rdchk(IDX_RECEIVE_DATA_BUFFER, 32'hff, 32'h2c);
    // the clock keeps running, so a push that overrun failed to block would show here
    repeat (100) @(posedge pclk);
    rdchk(IDX_FLAGS, 32'h1, 32'h0);
    wr(IDX_RECEIVE_STATUS_CONTROL, 32'h80);
    rdchk(IDX_RECEIVE_STATUS_CONTROL, 32'hff, 32'h80);
    rdchk(IDX_FLAGS, 32'h1, 32'h0);
    peer.bits_q.delete();
  endtask : t_overrun
  task t_slave_tx;
    wr(IDX_TRANSMIT_STATUS_CONTROL, 32'h10);
    `CHK(ck_oe, 1'b0)
    wr(IDX_ENABLES, 32'h2);
    wr(IDX_TRANSMIT_DATA_BUFFER, 32'h5a);
    wr(IDX_TRANSMIT_STATUS_CONTROL, 32'h30);
    wr(IDX_TRANSMIT_DATA_BUFFER, 32'hc3);
    core_sleep <= 1'b1;
    rdchk(IDX_FLAGS, 32'h2, 32'h0);
    `CHK(tx_irq, 1'b0)
    peer.pulses(8);
    repeat (8) @(posedge pclk);
    `CHK(cap, 8'h5a)
    `CHK({tx_irq, wake_req}, 2'b11)
    rdchk(IDX_FLAGS, 32'h2, 32'h2);
    peer.pulses(8);
    @(posedge pclk);
    `CHK(cap, 8'hc3)
    core_sleep <= 1'b0;
    wr(IDX_TRANSMIT_DATA_BUFFER, 32'h0f);
    peer.pulses(3);
    @(posedge pclk);
    wr(IDX_TRANSMIT_STATUS_CONTROL, 32'h10);
    `CHK(dt_oe, 1'b0)
    rdchk(IDX_TRANSMIT_STATUS_CONTROL, 32'hff, 32'h12);
  endtask : t_slave_tx
  initial
  begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    core_sleep = 1'b0;
    rd = 32'h0;
    err = 1'b0;
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    t_reset();
    t_single();
    t_overrun();
    t_slave_tx();
    tally_and_finish();
  end
endmodule : tb_usart_sync_rx_and_slave_tx
`default_nettype wire
